// ==== src/cdt_border_cmp.sv ====
// Window comparator for one measurement channel
`timescale 1ns/10ps
`default_nettype none
module cdt_border_cmp #(
   parameter int WIDTH = 6
) (
   // Measurement and borders
   input  wire logic [WIDTH-1:0] value,
   input  wire logic [WIDTH-1:0] lower,
   input  wire logic [WIDTH-1:0] upper,
   // Results
   output logic                  below,
   output logic                  above
);
   // Strict compares: a value equal to a border is still inside
   assign below = value < lower;
   assign above = value > upper;
endmodule : cdt_border_cmp
`default_nettype wire

// ==== src/cdt_irq_ctl.sv ====
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/10ps
`default_nettype none
module cdt_irq_ctl #(
   parameter int N = 3
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // Events and software access
   input  wire logic [N-1:0] event_set,
   input  wire logic         stat_wr,
   input  wire logic         mask_wr,
   input  wire logic [N-1:0] wdata,
   // State
   output logic      [N-1:0] status,
   output logic      [N-1:0] mask,
   output logic              irq
);
   // One sticky bit per event; a set in the clearing cycle wins
   for (genvar b = 0; b < N; b++) begin : g_stat
      always_ff @(posedge mclk) begin
         if (rst) begin
            status[b] <= 1'b0;
         end else if (event_set[b]) begin
            status[b] <= 1'b1;
         end else if (stat_wr && wdata[b]) begin
            status[b] <= 1'b0;
         end
      end
   end

   // Mask register, plain read/write
   always_ff @(posedge mclk) begin
      if (rst) begin
         mask <= cdt_pkg::RST_MASK;
      end else if (mask_wr) begin
         mask <= wdata;
      end
   end

   // Level output follows the masked status one cycle later
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & mask);
      end
   end
endmodule : cdt_irq_ctl
`default_nettype wire

// ==== src/cdt_pkg.sv ====
// Shared constants for the card-detect border compare block
package cdt_pkg;
   // Register interface widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int MEAS_W = 6;

   // Register byte offsets
   localparam logic [7:0] ADDR_Q_LOWER  = 8'h3F;
   localparam logic [7:0] ADDR_Q_UPPER  = 8'h40;
   localparam logic [7:0] ADDR_I_LOWER  = 8'h41;
   localparam logic [7:0] ADDR_I_RESULT = 8'h42;
   localparam logic [7:0] ADDR_Q_RESULT = 8'h43;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h50;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h51;

   // Field positions
   localparam int FIELD_MSB    = 5;
   localparam int SHARED_MSB   = 7;
   localparam int SHARED_LSB   = 6;
   localparam int SUPPRESS_BIT = 6;

   // Interrupt status layout
   localparam int IRQ_N       = 3;
   localparam int IRQ_DETECT  = 0;
   localparam int IRQ_I_CROSS = 1;
   localparam int IRQ_Q_CROSS = 2;

   // Reset values
   localparam logic [5:0] RST_LIMIT  = 6'h00;
   localparam logic [5:0] RST_RESULT = 6'h00;
   localparam logic [2:0] RST_MASK   = 3'h0;
   localparam logic [7:0] RST_RDATA  = 8'h00;
   localparam logic [7:0] UNMAPPED   = 8'h00;
endpackage : cdt_pkg

// ==== src/cdt_top.sv ====
// Low-power card detect borders, results and interrupt
//
// Contract
// - Bits 3 and 2 of the I upper limit live in bits 7 and 6 of the Q upper-limit register, read/write.
// - Bits 1 and 0 of the I upper limit live in bits 7 and 6 of the I lower-limit register.
// - An I measurement above the assembled I upper limit raises the card-detect interrupt.
// - The Q upper limit sits in bits 5..0 and a Q measurement above it raises the interrupt.
// - The I lower limit sits in bits 5..0 and an I measurement below it raises the interrupt.
// - The last I result reads in bits 5..0 of its register, with bits 7 and 6 reserved.
// - The last Q result reads in bits 5..0 of its register, with bit 7 reserved.
// - While the suppress bit 6 of the Q result register is set, no interrupt is raised until the next run.
// - The I upper limit is 6 bits and its bits 5 and 4 live in bits 7 and 6 of the Q lower-limit register.
// - The Q lower limit sits in bits 5..0 and a Q measurement below it raises the interrupt.
// - A card-detect request shows as the card-detect flag in the first interrupt register.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module cdt_top #(
   parameter int MEAS_W = cdt_pkg::MEAS_W
) (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // Register port
   input  wire logic [7:0]        addr,
   input  wire logic [7:0]        wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [7:0]        rdata,
   // Detection sequencer and measurement
   input  wire logic              det_start,
   input  wire logic              meas_done,
   input  wire logic [MEAS_W-1:0] meas_i,
   input  wire logic [MEAS_W-1:0] meas_q,
   // Interrupt
   output logic                   irq
);
   // Border and result state
   logic [MEAS_W-1:0] i_upper_limit;
   logic [MEAS_W-1:0] i_lower_limit;
   logic [MEAS_W-1:0] q_upper_limit;
   logic [MEAS_W-1:0] q_lower_limit;
   logic [MEAS_W-1:0] i_last;
   logic [MEAS_W-1:0] q_last;
   logic              detect_irq_suppress;
   logic              i_below;
   logic              i_above;
   logic              q_below;
   logic              q_above;
   logic              run_eval;
   logic [2:0]        event_set;
   logic [2:0]        status;
   logic [2:0]        mask;
   logic [7:0]        next_rdata;

   // Write decodes
   logic wr_q_lower;
   logic wr_q_upper;
   logic wr_i_lower;
   logic wr_q_result;
   logic wr_stat;
   logic wr_mask;

   assign wr_q_lower  = wr && (addr == cdt_pkg::ADDR_Q_LOWER);
   assign wr_q_upper  = wr && (addr == cdt_pkg::ADDR_Q_UPPER);
   assign wr_i_lower  = wr && (addr == cdt_pkg::ADDR_I_LOWER);
   assign wr_q_result = wr && (addr == cdt_pkg::ADDR_Q_RESULT);
   assign wr_stat     = wr && (addr == cdt_pkg::ADDR_IRQ_STAT);
   assign wr_mask     = wr && (addr == cdt_pkg::ADDR_IRQ_MASK);

   // I upper limit is spread over the top bits of three registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         i_upper_limit <= cdt_pkg::RST_LIMIT;
      end else begin
         if (wr_q_lower) begin
            i_upper_limit[5:4] <= wdata[7:6];
         end
         if (wr_q_upper) begin
            i_upper_limit[3:2] <= wdata[7:6];
         end
         if (wr_i_lower) begin
            i_upper_limit[1:0] <= wdata[7:6];
         end
      end
   end

   // Lower field of each limit register
   always_ff @(posedge mclk) begin
      if (rst) begin
         q_lower_limit <= cdt_pkg::RST_LIMIT;
         q_upper_limit <= cdt_pkg::RST_LIMIT;
         i_lower_limit <= cdt_pkg::RST_LIMIT;
      end else begin
         if (wr_q_lower) begin
            q_lower_limit <= wdata[5:0];
         end
         if (wr_q_upper) begin
            q_upper_limit <= wdata[5:0];
         end
         if (wr_i_lower) begin
            i_lower_limit <= wdata[5:0];
         end
      end
   end

   // Suppress bit: software sets it, the next run start releases it.
   // A software write in the start cycle wins, so a set is never lost.
   always_ff @(posedge mclk) begin
      if (rst) begin
         detect_irq_suppress <= 1'b0;
      end else if (wr_q_result) begin
         detect_irq_suppress <= wdata[cdt_pkg::SUPPRESS_BIT];
      end else if (det_start) begin
         detect_irq_suppress <= 1'b0;
      end
   end

   // Results are captured only at the end of a run, not tracked live
   always_ff @(posedge mclk) begin
      if (rst) begin
         i_last <= cdt_pkg::RST_RESULT;
         q_last <= cdt_pkg::RST_RESULT;
      end else if (meas_done) begin
         i_last <= meas_i;
         q_last <= meas_q;
      end
   end

   // Window compares on the fresh measurement
   cdt_border_cmp #(
      .WIDTH (MEAS_W)
   ) u_cmp_i (
      .value (meas_i),
      .lower (i_lower_limit),
      .upper (i_upper_limit),
      .below (i_below),
      .above (i_above)
   );

   cdt_border_cmp #(
      .WIDTH (MEAS_W)
   ) u_cmp_q (
      .value (meas_q),
      .lower (q_lower_limit),
      .upper (q_upper_limit),
      .below (q_below),
      .above (q_above)
   );

   // Compare result counts only in the completion cycle and while not suppressed
   assign run_eval = meas_done && !detect_irq_suppress;
   assign event_set[cdt_pkg::IRQ_I_CROSS] = run_eval && (i_above || i_below);
   assign event_set[cdt_pkg::IRQ_Q_CROSS] = run_eval && (q_above || q_below);
   assign event_set[cdt_pkg::IRQ_DETECT]  = event_set[cdt_pkg::IRQ_I_CROSS]
                                          || event_set[cdt_pkg::IRQ_Q_CROSS];

   // Sticky flags, mask and the interrupt pin
   cdt_irq_ctl #(
      .N (cdt_pkg::IRQ_N)
   ) u_irq (
      .mclk      (mclk),
      .rst       (rst),
      .event_set (event_set),
      .stat_wr   (wr_stat),
      .mask_wr   (wr_mask),
      .wdata     (wdata[2:0]),
      .status    (status),
      .mask      (mask),
      .irq       (irq)
   );

   // Read mux; reserved bits and unmapped offsets read as zero
   always_comb begin
      next_rdata = cdt_pkg::UNMAPPED;
      case (addr)
         cdt_pkg::ADDR_Q_LOWER:  next_rdata = {i_upper_limit[5:4], q_lower_limit};
         cdt_pkg::ADDR_Q_UPPER:  next_rdata = {i_upper_limit[3:2], q_upper_limit};
         cdt_pkg::ADDR_I_LOWER:  next_rdata = {i_upper_limit[1:0], i_lower_limit};
         cdt_pkg::ADDR_I_RESULT: next_rdata = {2'h0, i_last};
         cdt_pkg::ADDR_Q_RESULT: next_rdata = {1'h0, detect_irq_suppress, q_last};
         cdt_pkg::ADDR_IRQ_STAT: next_rdata = {5'h00, status};
         cdt_pkg::ADDR_IRQ_MASK: next_rdata = {5'h00, mask};
         default:                next_rdata = cdt_pkg::UNMAPPED;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= cdt_pkg::RST_RDATA;
      end else if (rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= cdt_pkg::RST_RDATA;
      end
   end

   // Checks on the border store, compare and interrupt paths
   i_upper_mid_a: assert property (@(posedge mclk) disable iff (rst)
      wr_q_upper |=> i_upper_limit[3:2] == $past(wdata[7:6]))
      else $error("I upper bits 3..2 not taken from Q upper write");

   i_upper_low_a: assert property (@(posedge mclk) disable iff (rst)
      wr_i_lower |=> (i_upper_limit[1:0] == $past(wdata[7:6])) && (i_lower_limit == $past(wdata[5:0])))
      else $error("I lower register write not split correctly");

   i_above_a: assert property (@(posedge mclk) disable iff (rst)
      (meas_done && !detect_irq_suppress && (meas_i > i_upper_limit)) |=> status[cdt_pkg::IRQ_DETECT])
      else $error("I above upper border did not set detect flag");

   q_above_a: assert property (@(posedge mclk) disable iff (rst)
      (meas_done && !detect_irq_suppress && (meas_q > q_upper_limit))
      |=> status[cdt_pkg::IRQ_DETECT] && status[cdt_pkg::IRQ_Q_CROSS])
      else $error("Q above upper border did not set flags");

   i_below_a: assert property (@(posedge mclk) disable iff (rst)
      (meas_done && !detect_irq_suppress && (meas_i < i_lower_limit))
      |=> status[cdt_pkg::IRQ_DETECT] && status[cdt_pkg::IRQ_I_CROSS])
      else $error("I below lower border did not set flags");

   i_result_rd_a: assert property (@(posedge mclk) disable iff (rst)
      (rd && addr == cdt_pkg::ADDR_I_RESULT) |=> rdata == {2'h0, $past(i_last)})
      else $error("I result read wrong");

   q_result_rd_a: assert property (@(posedge mclk) disable iff (rst)
      (rd && addr == cdt_pkg::ADDR_Q_RESULT) |=> (rdata[7] == 1'b0) && (rdata[5:0] == $past(q_last)))
      else $error("Q result read wrong");

   suppress_hold_a: assert property (@(posedge mclk) disable iff (rst)
      (detect_irq_suppress && !det_start && !wr_q_result)
      |=> !(status[cdt_pkg::IRQ_DETECT] && !$past(status[cdt_pkg::IRQ_DETECT]))
          && detect_irq_suppress)
      else $error("Detect flag rose while suppressed");

   i_upper_hi_a: assert property (@(posedge mclk) disable iff (rst)
      (wr_q_lower ##1 !wr_q_lower [*2]) |-> i_upper_limit[5:4] == $past(wdata[7:6], 2))
      else $error("I upper bits 5..4 lost after Q lower write");

   q_below_a: assert property (@(posedge mclk) disable iff (rst)
      (meas_done && !detect_irq_suppress && (meas_q < q_lower_limit)) |=> status[cdt_pkg::IRQ_Q_CROSS])
      else $error("Q below lower border did not set flag");

   irq_level_a: assert property (@(posedge mclk) disable iff (rst)
      (status[cdt_pkg::IRQ_DETECT] && mask[cdt_pkg::IRQ_DETECT]) |=> irq)
      else $error("Unmasked detect flag not on interrupt pin");

   result_latch_a: assert property (@(posedge mclk) disable iff (rst)
      !meas_done |-> !event_set[cdt_pkg::IRQ_DETECT] ##1 ($stable(i_last) && $stable(q_last)))
      else $error("Results moved outside a completion cycle");

   q_upper_lo_a: assert property (@(posedge mclk) disable iff (rst)
      wr_q_upper |=> q_upper_limit == $past(wdata[5:0]))
      else $error("Q upper border not taken from its write");

   q_lower_split_a: assert property (@(posedge mclk) disable iff (rst)
      wr_q_lower |=> (i_upper_limit[5:4] == $past(wdata[7:6])) && (q_lower_limit == $past(wdata[5:0])))
      else $error("Q lower register write not split correctly");

   i_above_flag_a: assert property (@(posedge mclk) disable iff (rst)
      (meas_done && !detect_irq_suppress && (meas_i > i_upper_limit)) |=> status[cdt_pkg::IRQ_I_CROSS])
      else $error("I above upper border did not set I flag");

   q_below_detect_a: assert property (@(posedge mclk) disable iff (rst)
      (meas_done && !detect_irq_suppress && (meas_q < q_lower_limit)) |=> status[cdt_pkg::IRQ_DETECT])
      else $error("Q below lower border did not set detect flag");

   suppressed_quiet_a: assert property (@(posedge mclk) disable iff (rst)
      (meas_done && detect_irq_suppress) |-> (event_set == 3'h0))
      else $error("Event raised while suppressed");

   suppress_set_a: assert property (@(posedge mclk) disable iff (rst)
      wr_q_result |=> detect_irq_suppress == $past(wdata[cdt_pkg::SUPPRESS_BIT]))
      else $error("Suppress bit not taken from its write");

   suppress_release_a: assert property (@(posedge mclk) disable iff (rst)
      (det_start && !wr_q_result) |=> !detect_irq_suppress)
      else $error("Suppress bit not released by a run start");

   // A new event must survive a clear written in the same cycle
   set_wins_a: assert property (@(posedge mclk) disable iff (rst)
      event_set[cdt_pkg::IRQ_DETECT] |=> status[cdt_pkg::IRQ_DETECT])
      else $error("Detect event lost against a clear");

   stat_clear_a: assert property (@(posedge mclk) disable iff (rst)
      (wr_stat && wdata[cdt_pkg::IRQ_DETECT] && !event_set[cdt_pkg::IRQ_DETECT])
      |=> !status[cdt_pkg::IRQ_DETECT])
      else $error("Detect flag not cleared by writing one");

   irq_quiet_a: assert property (@(posedge mclk) disable iff (rst)
      !(|(status & mask)) |=> !irq)
      else $error("Interrupt pin high with no unmasked flag");

   result_capture_a: assert property (@(posedge mclk) disable iff (rst)
      meas_done |=> (i_last == $past(meas_i)) && (q_last == $past(meas_q)))
      else $error("Results not captured at completion");

   // Main scenarios
   detect_irq_c: cover property (@(posedge mclk) disable iff (rst)
      run_eval && event_set[cdt_pkg::IRQ_DETECT] ##[1:3] irq);

   suppressed_run_c: cover property (@(posedge mclk) disable iff (rst)
      meas_done && detect_irq_suppress && (i_above || q_below));

   clear_race_c: cover property (@(posedge mclk) disable iff (rst)
      wr_stat && wdata[cdt_pkg::IRQ_DETECT] && event_set[cdt_pkg::IRQ_DETECT]);

   quiet_run_c: cover property (@(posedge mclk) disable iff (rst)
      det_start ##[1:20] (meas_done && !i_above && !i_below && !q_above && !q_below));
endmodule : cdt_top
`default_nettype wire

// ==== verification/cdt_tb.sv ====
// Self-checking bench for the card-detect border compare block
`timescale 1ns/10ps
`default_nettype none
module tb;
   // Design stimulus and observation
   logic       mclk;
   logic       rst;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       det_start;
   logic       meas_done;
   logic [5:0] meas_i;
   logic [5:0] meas_q;
   logic       irq;
   int         num_errors  = 0;
   int         check_count = 0;

   // Borders used throughout; the I upper limit spans all three shared fields
   localparam logic [5:0] I_UP  = 6'h2D;
   localparam logic [5:0] I_LOW = 6'h10;
   localparam logic [5:0] Q_UP  = 6'h30;
   localparam logic [5:0] Q_LOW = 6'h08;

   cdt_top #(.MEAS_W(6)) uut (
      .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .det_start(det_start), .meas_done(meas_done), .meas_i(meas_i), .meas_q(meas_q), .irq(irq)
   );

   // 10 MHz clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Single comparison point, so every mismatch is counted the same way
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe, so look just past that edge
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd   <= 1'b0;
      #1;
      chk(what, rdata, exp);
   endtask : rd_chk

   // One detection run; inputs are scrambled afterwards so a late capture shows
   task automatic run(input logic [5:0] i, input logic [5:0] q, input bit start);
      if (start) begin
         @(posedge mclk);
         det_start <= 1'b1;
      end
      @(posedge mclk);
      det_start <= 1'b0;
      meas_done <= 1'b1;
      meas_i    <= i;
      meas_q    <= q;
      @(posedge mclk);
      meas_done <= 1'b0;
      meas_i    <= ~i;
      meas_q    <= ~q;
   endtask : run

   task automatic reset_values;
      chk("irq idle", {7'h00, irq}, 8'h00);
      rd_chk("q lower reset", 8'h3F, 8'h00);
      rd_chk("q upper reset", 8'h40, 8'h00);
      rd_chk("i lower reset", 8'h41, 8'h00);
      rd_chk("i result reset", 8'h42, 8'h00);
      rd_chk("q result reset", 8'h43, 8'h00);
      rd_chk("status reset", 8'h50, 8'h00);
      rd_chk("mask reset", 8'h51, 8'h00);
      rd_chk("unmapped read", 8'h60, 8'h00);
   endtask : reset_values

   task automatic field_map;
      wr_reg(8'h3F, {2'b10, Q_LOW});
      wr_reg(8'h40, {2'b11, Q_UP});
      wr_reg(8'h41, {2'b01, I_LOW});
      wr_reg(8'h60, 8'hFF);
      rd_chk("q lower reg", 8'h3F, {2'b10, Q_LOW});
      rd_chk("q upper reg", 8'h40, {2'b11, Q_UP});
      rd_chk("i lower reg", 8'h41, {2'b01, I_LOW});
      wr_reg(8'h42, 8'hFF);
      rd_chk("i result read only", 8'h42, 8'h00);
      wr_reg(8'h43, 8'hBF);
      rd_chk("q result read only", 8'h43, 8'h00);
   endtask : field_map

   // Each case sits on or just across one border
   task automatic det_cases;
      logic [5:0] ci [8] = '{6'h20, 6'h2E, 6'h2D, 6'h0F, 6'h10, 6'h20, 6'h20, 6'h20};
      logic [5:0] cq [8] = '{6'h08, 6'h20, 6'h20, 6'h20, 6'h20, 6'h31, 6'h07, 6'h30};
      logic       ix;
      logic       qx;
      wr_reg(8'h51, 8'h07);
      for (int k = 0; k < 8; k++) begin
         ix = (ci[k] > I_UP) || (ci[k] < I_LOW);
         qx = (cq[k] > Q_UP) || (cq[k] < Q_LOW);
         run(ci[k], cq[k], 1'b1);
         rd_chk("status after run", 8'h50, {5'h00, qx, ix, ix | qx});
         chk("irq after run", {7'h00, irq}, {7'h00, ix | qx});
         rd_chk("i result", 8'h42, {2'b00, ci[k]});
         rd_chk("q result", 8'h43, {2'b00, cq[k]});
         wr_reg(8'h50, 8'h07);
         rd_chk("status cleared", 8'h50, 8'h00);
         chk("irq cleared", {7'h00, irq}, 8'h00);
      end
   endtask : det_cases

   task automatic suppress_chk;
      run(6'h20, 6'h20, 1'b1);
      wr_reg(8'h43, 8'h40);
      rd_chk("suppress set", 8'h43, 8'h60);
      run(6'h3F, 6'h3F, 1'b0);
      rd_chk("suppressed status", 8'h50, 8'h00);
      chk("suppressed irq", {7'h00, irq}, 8'h00);
      rd_chk("suppressed i result", 8'h42, 8'h3F);
      rd_chk("suppressed q result", 8'h43, 8'h7F);
      run(6'h3F, 6'h3F, 1'b1);
      rd_chk("status next run", 8'h50, 8'h07);
      rd_chk("suppress released", 8'h43, 8'h3F);
      wr_reg(8'h50, 8'h07);
   endtask : suppress_chk

   // An I-only crossing sets detect and I bits; only masking those passes it to irq
   task automatic mask_chk;
      for (int b = 0; b < 3; b++) begin
         wr_reg(8'h51, 8'h01 << b);
         run(6'h3F, 6'h20, 1'b1);
         rd_chk("mask status", 8'h50, 8'h03);
         chk("masked irq", {7'h00, irq}, {7'h00, b != 2});
         wr_reg(8'h51, 8'h00);
         rd_chk("mask off", 8'h51, 8'h00);
         chk("irq mask off", {7'h00, irq}, 8'h00);
         wr_reg(8'h50, 8'h07);
      end
   endtask : mask_chk

   // Same-cycle races: a new event beats a clear, a suppress write beats a run start
   task automatic race_chk;
      @(posedge mclk);
      meas_done <= 1'b1;
      meas_i    <= 6'h3F;
      meas_q    <= 6'h20;
      wr        <= 1'b1;
      addr      <= 8'h50;
      wdata     <= 8'h07;
      @(posedge mclk);
      meas_done <= 1'b0;
      wr        <= 1'b0;
      rd_chk("set beats clear", 8'h50, 8'h03);
      wr_reg(8'h50, 8'h07);
      @(posedge mclk);
      det_start <= 1'b1;
      wr        <= 1'b1;
      addr      <= 8'h43;
      wdata     <= 8'h40;
      @(posedge mclk);
      det_start <= 1'b0;
      wr        <= 1'b0;
      rd_chk("suppress beats start", 8'h43, 8'h60);
      wr_reg(8'h43, 8'h00);
   endtask : race_chk

   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   // Watchdog: a hung sequence still ends in the verdict
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      $display("[FAIL] watchdog expected finish seen timeout");
      report_and_stop();
   end

   // Main sequence
   initial begin
      rst       = 1'b1;
      addr      = 8'h00;
      wdata     = 8'h00;
      wr        = 1'b0;
      rd        = 1'b0;
      det_start = 1'b0;
      meas_done = 1'b0;
      meas_i    = 6'h00;
      meas_q    = 6'h00;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      reset_values();
      field_map();
      det_cases();
      suppress_chk();
      mask_chk();
      race_chk();
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
